// file: hw/csd_pkg.sv
// Constants and types shared by the compare/skip/decrement/BCD unit
package csd_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets on the AXI4-Lite slave)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_FLAGS = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_WIDX = 8'h0C;
    localparam logic [7:0] OFF_WDATA = 8'h10;
    localparam logic [7:0] OFF_MADDR = 8'h14;
    localparam logic [7:0] OFF_MDATA = 8'h18;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------
    localparam logic [7:0] OPC_CMP = 8'hE7;
    localparam logic [7:0] OPC_DECF = 8'hED;
    localparam logic [7:0] OPC_DECR = 8'hE9;
    localparam logic [19:0] OPC_DAW = 20'hFD400;
    localparam logic [4:0] CMP_PAD = 5'h00;
    localparam logic [3:0] DEFAULT_ACC = 4'h0;

    // ------------------------------------------------------------
    // Flag word layout and reset values
    // ------------------------------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_OV = 2;
    localparam int FLG_N = 3;
    localparam int FLG_DC = 8;
    localparam logic [15:0] FLAG_MASK = 16'h010F;
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] DEFAULT_ACCUMULATOR_RST = 16'h0000;
    localparam logic [7:0] MEM_RST = 8'h00;
    localparam int MEM_BYTES = 256;
    localparam int NUM_WREGS = 16;
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [7:0] BCD_LO_FIX = 8'h06;
    localparam logic [8:0] BCD_HI_FIX = 9'h060;

    // ------------------------------------------------------------
    // Operand addressing modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_DIRECT = 3'b000,
        MODE_IND = 3'b001,
        MODE_POSTDEC = 3'b010,
        MODE_POSTINC = 3'b011,
        MODE_PREDEC = 3'b100,
        MODE_PREINC = 3'b101
    } csd_mode_type;

endpackage : csd_pkg

// file: hw/csd_unit.sv
// Compare/skip, BCD fixup and decrement execution unit, AXI4-Lite slave
//
// Functional notes
// - Decode compare-skip-if-unequal: base reg, width bit, pad 0000, second reg.
// - Alternate compare encoding carries 0001 ahead of second reg field.
// - Decode BCD fixup: fixed pattern plus one register, direct only.
// - File decrement by one; target bit picks accumulator or file register.
// - All decrements update DC, N, OV, Z, C at the selected width.
// - Register decrement by one: decode modes and regs, write destination.
// - File decrement by two with same target selection as by one.
// - Register decrement by two decodes width, modes and register fields.
// - Register decrement by two stores source minus two via destination.
// - Six addressing modes, independently for source and destination.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module csd_unit (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] wFile_reg [csd_pkg::NUM_WREGS];
    logic [7:0] dataMem_reg [csd_pkg::MEM_BYTES];
    logic [15:0] flag_reg;
    logic skipPending_reg;
    logic badOp_reg;
    logic [23:0] instr_reg;
    logic [3:0] wIdx_reg;
    logic [7:0] mAddr_reg;
    logic awHeld_reg, wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;

    logic doWrite, execFire, execLive;
    logic [31:0] wrMerged;
    logic [23:0] op;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] mergeStrb(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : mergeStrb

    function automatic logic isCmpOp(input logic [23:0] w);
        // Both variants of the pad field (low bit 0 or 1) are accepted
        return w[23:16] == csd_pkg::OPC_CMP && !w[15]
            && w[9:5] == csd_pkg::CMP_PAD;
    endfunction : isCmpOp

    function automatic logic [15:0] accessAddr(input logic [2:0] m,
            input logic [15:0] ptr, input logic [15:0] step);
        unique case (csd_pkg::csd_mode_type'(m))
            csd_pkg::MODE_PREDEC: return ptr - step;
            csd_pkg::MODE_PREINC: return ptr + step;
            default: return ptr;
        endcase
    endfunction : accessAddr

    function automatic logic [15:0] updatedPtr(input logic [2:0] m,
            input logic [15:0] ptr, input logic [15:0] step);
        unique case (csd_pkg::csd_mode_type'(m))
            csd_pkg::MODE_POSTDEC, csd_pkg::MODE_PREDEC: return ptr - step;
            csd_pkg::MODE_POSTINC, csd_pkg::MODE_PREINC: return ptr + step;
            default: return ptr;
        endcase
    endfunction : updatedPtr

    // Word reads ignore address bit 0, as the core does for word access
    function automatic logic [15:0] readMem(input logic [7:0] a,
            input logic byteOp);
        if (byteOp) begin
            return {8'h00, dataMem_reg[a]};
        end
        return {dataMem_reg[{a[7:1], 1'b1}], dataMem_reg[{a[7:1], 1'b0}]};
    endfunction : readMem

    function automatic logic [15:0] decFlags(input logic [15:0] a,
            input logic [15:0] k, input logic byteOp);
        logic [15:0] f;
        logic [15:0] r;
        f = '0;
        r = a - k;
        f[csd_pkg::FLG_DC] = a[3:0] >= k[3:0];
        if (byteOp) begin
            f[csd_pkg::FLG_N] = r[7];
            f[csd_pkg::FLG_Z] = r[7:0] == 8'h00;
            f[csd_pkg::FLG_C] = a[7:0] >= k[7:0];
            f[csd_pkg::FLG_OV] = a[7] & ~r[7];
        end else begin
            f[csd_pkg::FLG_N] = r[15];
            f[csd_pkg::FLG_Z] = r == 16'h0000;
            f[csd_pkg::FLG_C] = a >= k;
            f[csd_pkg::FLG_OV] = a[15] & ~r[15];
        end
        return f;
    endfunction : decFlags

    // ------------------------------------------------------------
    // Instruction execution (single cycle, on write to INSTR)
    // ------------------------------------------------------------
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
    assign wrMerged = mergeStrb({8'h00, instr_reg}, wData_reg, wStrb_reg);
    assign op = wrMerged[23:0];
    assign execFire = doWrite && awAddr_reg == csd_pkg::OFF_INSTR;
    // A pending skip turns this slot into a no-operation
    assign execLive = execFire && !skipPending_reg;

    logic isCmp, isDecF, isDecR, isDaw, knownOp, byteOp, skipSet;
    logic aEn, bEn, memWe, flagsWe;
    logic [3:0] aIdx, bIdx;
    logic [15:0] aVal, bVal, memVal, flagsVal, stepV, kV, opA, opB, res;
    logic [7:0] memAddr;
    logic [15:0] sPtr, sAddr, sNew, dPtr, dAddr, dNew;
    logic [8:0] bcd;

    always_comb begin
        isCmp = isCmpOp(op);
        isDecF = op[23:16] == csd_pkg::OPC_DECF;
        isDecR = op[23:16] == csd_pkg::OPC_DECR && op[13:11] <= 3'b101
            && op[6:4] <= 3'b101;
        isDaw = op[23:4] == csd_pkg::OPC_DAW;
        knownOp = isCmp || isDecF || isDecR || isDaw;
        byteOp = isCmp ? op[10] : op[14];
        stepV = byteOp ? csd_pkg::STEP_BYTE : csd_pkg::STEP_WORD;
        kV = op[15] ? csd_pkg::STEP_WORD : csd_pkg::STEP_BYTE;
        aEn = 1'b0;
        aIdx = op[3:0];
        aVal = '0;
        bEn = 1'b0;
        bIdx = op[10:7];
        bVal = '0;
        memWe = 1'b0;
        memAddr = '0;
        memVal = '0;
        flagsWe = 1'b0;
        flagsVal = flag_reg;
        skipSet = 1'b0;
        sPtr = wFile_reg[op[3:0]];
        sAddr = accessAddr(op[6:4], sPtr, stepV);
        sNew = updatedPtr(op[6:4], sPtr, stepV);
        dPtr = (op[10:7] == op[3:0] && op[6:4] != 3'b000) ? sNew
            : wFile_reg[op[10:7]];
        dAddr = accessAddr(op[13:11], dPtr, stepV);
        dNew = updatedPtr(op[13:11], dPtr, stepV);
        opA = '0;
        opB = '0;
        res = '0;
        bcd = '0;
        if (isCmp) begin
            // Difference is only a skip decision, flags untouched
            opA = wFile_reg[op[14:11]];
            opB = wFile_reg[op[3:0]];
            res = opA - opB;
            skipSet = byteOp ? res[7:0] != 8'h00 : res != 16'h0000;
        end else if (isDecF) begin
            memAddr = op[7:0];
            opA = readMem(op[7:0], byteOp);
            res = opA - kV;
            flagsWe = 1'b1;
            flagsVal = (flag_reg & ~csd_pkg::FLAG_MASK)
                | decFlags(opA, kV, byteOp);
            if (op[13]) begin
                memWe = 1'b1;
                memVal = res;
            end else begin
                bEn = 1'b1;
                bIdx = csd_pkg::DEFAULT_ACC;
                bVal = byteOp ? {wFile_reg[csd_pkg::DEFAULT_ACC][15:8],
                    res[7:0]} : res;
            end
        end else if (isDecR) begin
            opA = op[6:4] == 3'b000 ? sPtr : readMem(sAddr[7:0], byteOp);
            res = opA - kV;
            flagsWe = 1'b1;
            flagsVal = (flag_reg & ~csd_pkg::FLAG_MASK)
                | decFlags(opA, kV, byteOp);
            aEn = op[6:4] != 3'b000 && op[6:4] != 3'b001;
            aVal = sNew;
            bEn = 1'b1;
            if (op[13:11] == 3'b000) begin
                bVal = byteOp ? {dPtr[15:8], res[7:0]} : res;
            end else begin
                memWe = 1'b1;
                memAddr = dAddr[7:0];
                memVal = res;
                bEn = op[13:11] != 3'b001;
                bVal = dNew;
            end
        end else if (isDaw) begin
            bcd = {1'b0, sPtr[7:0]};
            if (bcd[3:0] > csd_pkg::BCD_MAX || flag_reg[csd_pkg::FLG_DC]) begin
                bcd = bcd + {1'b0, csd_pkg::BCD_LO_FIX};
            end
            if (bcd[8] || bcd[7:4] > csd_pkg::BCD_MAX
                    || flag_reg[csd_pkg::FLG_C]) begin
                bcd = bcd + csd_pkg::BCD_HI_FIX;
            end
            bEn = 1'b1;
            bIdx = op[3:0];
            bVal = {sPtr[15:8], bcd[7:0]};
            flagsWe = 1'b1;
            flagsVal[csd_pkg::FLG_C] = flag_reg[csd_pkg::FLG_C] | bcd[8];
        end
    end

    // ------------------------------------------------------------
    // Working registers and data memory
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < csd_pkg::NUM_WREGS; i++) begin
                wFile_reg[i] <= csd_pkg::DEFAULT_ACCUMULATOR_RST;
            end
        end else if (execLive) begin
            if (aEn) begin
                wFile_reg[aIdx] <= aVal;
            end
            // Port B wins: destination write overrides source update
            if (bEn) begin
                wFile_reg[bIdx] <= bVal;
            end
        end else if (doWrite && awAddr_reg == csd_pkg::OFF_WDATA) begin
            wFile_reg[wIdx_reg] <= 16'(mergeStrb({16'h0000,
                wFile_reg[wIdx_reg]}, wData_reg, wStrb_reg));
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < csd_pkg::MEM_BYTES; i++) begin
                dataMem_reg[i] <= csd_pkg::MEM_RST;
            end
        end else if (execLive && memWe) begin
            if (byteOp) begin
                dataMem_reg[memAddr] <= memVal[7:0];
            end else begin
                dataMem_reg[{memAddr[7:1], 1'b0}] <= memVal[7:0];
                dataMem_reg[{memAddr[7:1], 1'b1}] <= memVal[15:8];
            end
        end else if (doWrite && awAddr_reg == csd_pkg::OFF_MDATA) begin
            if (wStrb_reg[0]) begin
                dataMem_reg[{mAddr_reg[7:1], 1'b0}] <= wData_reg[7:0];
            end
            if (wStrb_reg[1]) begin
                dataMem_reg[{mAddr_reg[7:1], 1'b1}] <= wData_reg[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Flags, skip and control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_reg <= csd_pkg::FLAGS_RST;
        end else if (execLive && flagsWe) begin
            flag_reg <= flagsVal & csd_pkg::FLAG_MASK;
        end else if (doWrite && awAddr_reg == csd_pkg::OFF_FLAGS) begin
            flag_reg <= 16'(mergeStrb({16'h0000, flag_reg}, wData_reg,
                wStrb_reg)) & csd_pkg::FLAG_MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            skipPending_reg <= 1'b0;
            badOp_reg <= 1'b0;
            instr_reg <= '0;
        end else if (execFire) begin
            skipPending_reg <= execLive && isCmp && skipSet;
            badOp_reg <= execLive && !knownOp;
            instr_reg <= op;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wIdx_reg <= '0;
            mAddr_reg <= '0;
        end else if (doWrite && awAddr_reg == csd_pkg::OFF_WIDX) begin
            wIdx_reg <= wStrb_reg[0] ? wData_reg[3:0] : wIdx_reg;
        end else if (doWrite && awAddr_reg == csd_pkg::OFF_MADDR) begin
            mAddr_reg <= wStrb_reg[0] ? wData_reg[7:0] : mAddr_reg;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] a);
        return a <= csd_pkg::OFF_MDATA && a[1:0] == 2'b00;
    endfunction : mapped

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= csd_pkg::RESP_OKAY;
        end else begin
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awAddr_reg) ? csd_pkg::RESP_OKAY
                    : csd_pkg::RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHeld_reg <= 1'b1;
                    awAddr_reg <= s_axi_awaddr;
                    s_axi_awready <= 1'b0;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHeld_reg <= 1'b1;
                    wData_reg <= s_axi_wdata;
                    wStrb_reg <= s_axi_wstrb;
                    s_axi_wready <= 1'b0;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channels
    // ------------------------------------------------------------
    logic [31:0] rdNext;

    always_comb begin
        unique case (s_axi_araddr)
            csd_pkg::OFF_INSTR: rdNext = {8'h00, instr_reg};
            csd_pkg::OFF_FLAGS: rdNext = {16'h0000, flag_reg};
            csd_pkg::OFF_STATUS: rdNext = {30'h0, badOp_reg, skipPending_reg};
            csd_pkg::OFF_WIDX: rdNext = {28'h0, wIdx_reg};
            csd_pkg::OFF_WDATA: rdNext = {16'h0000, wFile_reg[wIdx_reg]};
            csd_pkg::OFF_MADDR: rdNext = {24'h0, mAddr_reg};
            csd_pkg::OFF_MDATA: rdNext = {16'h0000, readMem(mAddr_reg, 1'b0)};
            default: rdNext = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= csd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdNext;
            s_axi_rresp <= mapped(s_axi_araddr) ? csd_pkg::RESP_OKAY
                : csd_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_cmp_decode_a: assert property (execFire && op[23:16] == 8'hE7
        && !op[15] && op[9:4] == 6'h00 |-> isCmp)
        else $error("compare encoding with pad 0000 not decoded");
    a_cmp_decode_b: assert property (execFire && op[23:16] == 8'hE7
        && !op[15] && op[9:4] == 6'h01 |-> isCmp)
        else $error("compare encoding with pad 0001 not decoded");
    a_skip_one_slot: assert property (execFire && skipPending_reg
        |=> !skipPending_reg && flag_reg == $past(flag_reg)
        && !badOp_reg)
        else $error("skipped slot did not act as a no-operation");
    a_cmp_keeps_flags: assert property (execLive && isCmp
        |=> flag_reg == $past(flag_reg))
        else $error("compare altered the flag word");
    a_daw_nibbles: assert property (execLive && isDaw
        |=> wFile_reg[$past(op[3:0])][3:0] <= 4'h9
        && wFile_reg[$past(op[3:0])][15:8] == $past(sPtr[15:8]))
        else $error("BCD fixup left low nibble out of range");
    a_decf_to_acc: assert property (execLive && isDecF && !op[13]
        && !op[14] |=> wFile_reg[0] == $past(opA) - $past(kV))
        else $error("file decrement result wrong in accumulator");
    a_dec_zero_flag: assert property (execLive && (isDecF || isDecR)
        |=> flag_reg[1] == ($past(byteOp) ? $past(res[7:0]) == 8'h00
        : $past(res) == 16'h0000))
        else $error("zero flag does not match decrement result");
    a_subtract_two_op_direct: assert property (execLive && isDecR && op[15]
        && !op[14] && op[13:11] == 3'b000 && op[6:4] == 3'b000
        |=> wFile_reg[$past(op[10:7])] == $past(sPtr) - 16'h0002)
        else $error("decrement by two direct result wrong");
    a_src_postinc: assert property (execLive && isDecR
        && op[6:4] == 3'b011 && op[10:7] != op[3:0]
        |=> wFile_reg[$past(op[3:0])] == $past(sPtr) + $past(stepV))
        else $error("source post-increment pointer wrong");
    a_write_resp: assert property (doWrite |=> s_axi_bvalid
        && s_axi_awready && s_axi_wready)
        else $error("write response not raised after write");

    c_skip_taken: cover property (execLive && isCmp && skipSet
        ##[3:40] execFire);
    c_daw_roll: cover property (execLive && isDaw && bcd[8]);
    c_subtract_two_op_postinc: cover property (execLive && isDecR && op[15]
        && op[13:11] == 3'b011);
    c_bad_read: cover property (s_axi_rvalid
        && s_axi_rresp == csd_pkg::RESP_SLVERR);

endmodule : csd_unit
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the compare/skip/decrement/BCD unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [15:0] w1, w2, fl0;
        logic [23:0] ins;
        logic [3:0] ridx;
        logic [15:0] res, fl;
    } csd_row_type;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    int fails = 0, totalChecks = 0, cyc = 0;
    // Index 15 stands for the data word at the fixed file address
    csd_row_type rows [10] = '{
        '{16'h0001, 16'h0, 16'h0, 24'hE90181, 4'h3, 16'h0000, 16'h0103},
        '{16'h1280, 16'h0, 16'h0, 24'hE9C081, 4'h1, 16'h127E, 16'h0005},
        '{16'h0000, 16'h20, 16'h0, 24'hE90192, 4'h3, 16'hFFFF, 16'h0008},
        '{16'hD004, 16'h20, 16'h0, 24'hE99901, 4'hF, 16'hD002, 16'h0109},
        '{16'h80FF, 16'h0, 16'h0, 24'hED6020, 4'hF, 16'h80FE, 16'h0109},
        '{16'h0823, 16'h0, 16'h0, 24'hED8020, 4'h0, 16'h0821, 16'h0101},
        '{16'h771A, 16'h0, 16'h100, 24'hFD4001, 4'h1, 16'h7720, 16'h0100},
        '{16'h77AA, 16'h0, 16'h0, 24'hFD4001, 4'h1, 16'h7710, 16'h0001},
        '{16'h3000, 16'h3000, 16'h10F, 24'hE70802, 4'h1, 16'h3000, 16'h10F},
        '{16'h0010, 16'h22, 16'h0, 24'hE901C2, 4'h3, 16'h000F, 16'h0001}};
    csd_unit csd_unit_inst (.core_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #2 core_clk = ~core_clk;
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            printVerdict();
        end
    end
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // wr and rdr first let an edge pass so a lowered strobe is seen low
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw, w;
        aw = 1;
        w = 1;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end while (aw || w || !s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rdr
    task automatic setw(input logic [3:0] i, input logic [15:0] v);
        wr(csd_pkg::OFF_WIDX, {28'h0, i});
        wr(csd_pkg::OFF_WDATA, {16'h0, v});
    endtask : setw
    task automatic printVerdict();
        $display("checks=%0d fails=%0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : printVerdict
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        check({27'h0, s_axi_awready, s_axi_wready, s_axi_arready,
            s_axi_bvalid, s_axi_rvalid}, 32'h1C);
        rst_b <= 1'b1;
        rdr(csd_pkg::OFF_FLAGS);
        check(rd, {16'h0, csd_pkg::FLAGS_RST});
        wr(csd_pkg::OFF_MADDR, 32'h20);
        foreach (rows[i]) begin
            setw(4'h1, rows[i].w1);
            setw(4'h2, rows[i].w2);
            wr(csd_pkg::OFF_MDATA, {16'h0, rows[i].w1});
            wr(csd_pkg::OFF_FLAGS, {16'h0, rows[i].fl0});
            wr(csd_pkg::OFF_INSTR, {8'h00, rows[i].ins});
            if (rows[i].ridx == 4'hF) begin
                rdr(csd_pkg::OFF_MDATA);
            end else begin
                wr(csd_pkg::OFF_WIDX, {28'h0, rows[i].ridx});
                rdr(csd_pkg::OFF_WDATA);
            end
            check(rd, {16'h0, rows[i].res});
            rdr(csd_pkg::OFF_FLAGS);
            check(rd, {16'h0, rows[i].fl});
        end
        setw(4'h1, 16'h00FF);
        setw(4'h2, 16'h26FE);
        wr(csd_pkg::OFF_INSTR, 32'hE70C12);
        rdr(csd_pkg::OFF_STATUS);
        check(rd, 32'h1);
        wr(csd_pkg::OFF_INSTR, 32'hE90081);
        rdr(csd_pkg::OFF_STATUS);
        check(rd, 32'h0);
        wr(csd_pkg::OFF_WIDX, 32'h1);
        rdr(csd_pkg::OFF_WDATA);
        check(rd, 32'h00FF);
        setw(4'h2, 16'h34FF);
        wr(csd_pkg::OFF_INSTR, 32'hE70C02);
        rdr(csd_pkg::OFF_STATUS);
        check(rd, 32'h0);
        wr(8'h40, 32'h0);
        check({30'h0, resp}, {30'h0, csd_pkg::RESP_SLVERR});
        rdr(8'h40);
        check({rd[29:0], resp}, {30'h0, csd_pkg::RESP_SLVERR});
        printVerdict();
    end
endmodule : tb_top
`default_nettype wire
